// ### dma_event_map.svh
`ifndef DMA_EVENT_MAP_SVH
`define DMA_EVENT_MAP_SVH

`define REASON_OFFSET         8'h50
`define ENABLE_OFFSET         8'h54
`define SHORT_ABORT_BIT       15
`define GENERIC_STOP_BIT      12
`define EXTERNAL_END_BIT      11
`define INTERNAL_END_BIT      10
`define DEVICE_IRQ_BIT        9
`define COUNT_DONE_BIT        8
`define DATA_UNREAD_BIT       4
`define BUSY_POLL_BIT         3
`define TASKFILE_READ_BIT     2
`define COMMAND_IRQ_BIT       1
`define REASON_RESET          16'h0000
`define ENABLE_RESET          16'h0000
`define WRITABLE_MASK         16'h1F1E
`define REASON_IMPL_MASK      16'h9F1E

`endif

// ### dma_event_pkg.sv
package dma_event_pkg;
    typedef logic [15:0] event_word_t;
    typedef enum logic [1:0] {
        DMA_MODE_OTHER   = 2'h0,
        DMA_MODE_GENERIC = 2'h1,
        DMA_MODE_MASTER  = 2'h3
    } dma_mode_t;
endpackage

// ### dma_interrupt_reason_enable.sv
`timescale 1ns/1ps
`default_nettype none
`include "dma_event_map.svh"

// Notes on behaviour
// - sixteen-bit reason register at 50h, bits 15, 12, 11, 10 and 8 refreshed as each dma command finishes.
// - writing one clears a latched reason bit; zero leaves it.
// - bit 15 flags a short out packet abort; read only.
// - bit 12 sets when the generic stop command is written.
// - bit 11 sets on external end of transfer, generic slave mode only.
// - bit 10 sets on internal end of transfer from a short packet.
// - internal end and count done together encode how the transfer ended.
// - bit 9 sets on a pending interrupt at the device irq pin.
// - bit 8 sets when the counter reaches zero, generic or master mode.
// - bit 4 sets while the data port fifo holds unread data.
// - bit 3 sets when busy polling sees busy clear and stops.
// - bit 2 sets when the task file read command completes.
// - bit 1 sets only with count zero and a device irq together.
// - sixteen-bit enable register at 54h mirrors the reason layout.
// - usb bus reset clears every enable bit.
// - enable bit 15 always reads zero.
// - one dma interrupt line feeds the main interrupt register.
module dma_interrupt_reason_enable
    import dma_event_pkg::*;
(
    input  wire logic        sys_clk,
    input  wire logic        rstn,
    input  wire logic        bus_reset,
    input  wire logic [7:0]  reg_addr,
    input  wire logic [15:0] reg_wdata,
    input  wire logic        reg_wr,
    input  wire logic        reg_rd,
    output var  logic [15:0] reg_rdata,
    input  wire dma_mode_t   dma_mode,
    input  wire logic        command_done,
    input  wire logic        short_packet_abort_status,
    input  wire logic        generic_stop_done,
    input  wire logic        external_end_of_transfer,
    input  wire logic        internal_end_of_transfer,
    input  wire logic        transfer_count_done,
    input  wire logic        data_port_unread,
    input  wire logic        busy_poll_done,
    input  wire logic        taskfile_read_done,
    input  wire logic        device_irq_pin,
    output var  logic        dma_irq
);

    // register strobes decoded once from the plain bus
    logic        wr_reason;
    logic        wr_enable;
    logic        rd_reason;
    logic        rd_enable;

    // register state and next values
    event_word_t reason_q;
    event_word_t reason_d;
    event_word_t enable_q;
    event_word_t enable_d;
    event_word_t rdata_d;
    logic        irq_d;

    // event set, software clear and surviving bits
    event_word_t events_d;
    event_word_t clear_d;
    event_word_t kept_d;

    // one set strobe per source
    logic        set_abort;
    logic        set_stop;
    logic        set_ext_end;
    logic        set_int_end;
    logic        set_count;
    logic        set_unread;
    logic        set_busy;
    logic        set_taskfile;
    logic        set_command_irq;
    logic        set_device_irq;

    // mode qualifiers
    logic        mode_slave;
    logic        mode_counts;

    // pin synchroniser and edge detector
    logic        irq_meta_q;
    logic        irq_sync_q;
    logic        irq_prev_q;
    logic        irq_edge;

    // address match shared by the read and write decoders
    function automatic logic hit(
        input logic [7:0] a,
        input logic [7:0] off
    );
        return a == off;
    endfunction

    // external end of transfer only counts in generic slave mode
    function automatic logic is_slave_mode(
        input dma_mode_t md
    );
        return md == DMA_MODE_GENERIC;
    endfunction

    // the transfer counter only runs in generic slave and multiword master modes
    function automatic logic is_counting_mode(
        input dma_mode_t md
    );
        return (md == DMA_MODE_GENERIC) || (md == DMA_MODE_MASTER);
    endfunction

    // new events are or-ed in after the clear, so a set wins over a clear
    function automatic event_word_t merge_events(
        input event_word_t kept,
        input event_word_t set
    );
        return (kept | set) & `REASON_IMPL_MASK;
    endfunction

    // unmapped addresses read as zero
    function automatic event_word_t read_word(
        input logic        sel_reason,
        input logic        sel_enable,
        input event_word_t reason,
        input event_word_t enable
    );
        if (sel_reason) begin
            return reason;
        end
        if (sel_enable) begin
            return enable;
        end
        return 16'h0000;
    endfunction

    always_comb begin
        wr_reason = reg_wr && hit(reg_addr, `REASON_OFFSET);
        wr_enable = reg_wr && hit(reg_addr, `ENABLE_OFFSET);
        rd_reason = reg_rd && hit(reg_addr, `REASON_OFFSET);
        rd_enable = reg_rd && hit(reg_addr, `ENABLE_OFFSET);
    end

    always_comb begin
        mode_slave  = is_slave_mode(dma_mode);
        mode_counts = is_counting_mode(dma_mode);
    end

    // the irq pin is asynchronous; two flops before any logic reads it
    always_ff @(posedge sys_clk or negedge rstn) begin
        if (!rstn) begin
            irq_meta_q <= 1'b0;
        end else begin
            irq_meta_q <= device_irq_pin;
        end
    end

    always_ff @(posedge sys_clk or negedge rstn) begin
        if (!rstn) begin
            irq_sync_q <= 1'b0;
        end else begin
            irq_sync_q <= irq_meta_q;
        end
    end

    // reset level matches the idle pin, so no false edge after reset
    always_ff @(posedge sys_clk or negedge rstn) begin
        if (!rstn) begin
            irq_prev_q <= 1'b0;
        end else begin
            irq_prev_q <= irq_sync_q;
        end
    end

    assign irq_edge = irq_sync_q & ~irq_prev_q;

    // command-driven sources latch only as a dma command completes
    always_comb begin
        set_abort = command_done & short_packet_abort_status;
        set_stop  = command_done & generic_stop_done;
    end

    always_comb begin
        set_ext_end = command_done & external_end_of_transfer & mode_slave;
    end

    // internal end and count done stay independent; the pair encodes the outcome
    always_comb begin
        set_int_end = command_done & internal_end_of_transfer;
    end

    always_comb begin
        set_count = command_done & transfer_count_done & mode_counts;
    end

    // status sources set on every cycle that they stand high; the device irq pin sets only on its rising edge
    always_comb begin
        set_unread = data_port_unread;
    end

    always_comb begin
        set_busy     = busy_poll_done;
        set_taskfile = taskfile_read_done;
    end

    always_comb begin
        set_device_irq = irq_edge;
    end

    // bit 1 needs a finished count and a pending pin at once
    always_comb begin
        set_command_irq = transfer_count_done & irq_sync_q;
    end

    always_comb begin
        events_d                     = 16'h0000;
        events_d[`SHORT_ABORT_BIT]   = set_abort;
        events_d[`GENERIC_STOP_BIT]  = set_stop;
        events_d[`EXTERNAL_END_BIT]  = set_ext_end;
        events_d[`INTERNAL_END_BIT]  = set_int_end;
        events_d[`DEVICE_IRQ_BIT]    = set_device_irq;
        events_d[`COUNT_DONE_BIT]    = set_count;
        events_d[`DATA_UNREAD_BIT]   = set_unread;
        events_d[`BUSY_POLL_BIT]     = set_busy;
        events_d[`TASKFILE_READ_BIT] = set_taskfile;
        events_d[`COMMAND_IRQ_BIT]   = set_command_irq;
    end

    // bit 15 is outside the writable mask, so software cannot clear it
    always_comb begin
        clear_d = 16'h0000;
        if (wr_reason) begin
            clear_d = reg_wdata & `WRITABLE_MASK;
        end
    end

    // bits that survive this cycle's write-one clear
    always_comb begin
        kept_d = reason_q & ~clear_d;
    end

    // usb bus reset empties the reason word as well
    always_comb begin
        reason_d = merge_events(kept_d, events_d);
        if (bus_reset) begin
            reason_d = `REASON_RESET;
        end
    end

    always_ff @(posedge sys_clk or negedge rstn) begin
        if (!rstn) begin
            reason_q <= `REASON_RESET;
        end else begin
            reason_q <= reason_d;
        end
    end

    // bit 15 is never stored, so the abort status cannot interrupt
    always_comb begin
        enable_d = enable_q;
        if (bus_reset) begin
            enable_d = `ENABLE_RESET;
        end else if (wr_enable) begin
            enable_d = reg_wdata & `WRITABLE_MASK;
        end
    end

    always_ff @(posedge sys_clk or negedge rstn) begin
        if (!rstn) begin
            enable_q <= `ENABLE_RESET;
        end else begin
            enable_q <= enable_d;
        end
    end

    // read data stand for one cycle only, zero otherwise
    always_comb begin
        rdata_d = read_word(rd_reason, rd_enable, reason_q, enable_q);
    end

    always_ff @(posedge sys_clk or negedge rstn) begin
        if (!rstn) begin
            reg_rdata <= 16'h0000;
        end else begin
            reg_rdata <= rdata_d;
        end
    end

    // one registered line into the main interrupt register
    always_comb begin
        irq_d = |(reason_q & enable_q);
    end

    always_ff @(posedge sys_clk or negedge rstn) begin
        if (!rstn) begin
            dma_irq <= 1'b0;
        end else begin
            dma_irq <= irq_d;
        end
    end

endmodule // dma_interrupt_reason_enable

`default_nettype wire

// ### dma_event_chk.sv
`timescale 1ns/1ps
`default_nettype none
module dma_event_chk (
    input wire logic        sys_clk,
    input wire logic        rstn,
    input wire logic        bus_reset,
    input wire logic [7:0]  reg_addr,
    input wire logic        reg_rd,
    input wire logic [15:0] reg_rdata,
    input wire logic        data_port_unread,
    input wire logic        busy_poll_done,
    input wire logic        dma_irq
);
    default clocking @(posedge sys_clk); endclocking
    default disable iff (!rstn);
    wire rd_reason = reg_rd && reg_addr == 8'h50;
    wire rd_enable = reg_rd && reg_addr == 8'h54;
    a_idle_rdata: assert property (!reg_rd |=> reg_rdata == '0) else $error("rdata");
    a_unmapped_zero: assert property (reg_rd && !rd_reason && !rd_enable |=> reg_rdata == '0)
        else $error("unmapped read");
    a_enable_bits: assert property (rd_enable |=> (reg_rdata & 16'hE0E1) == '0)
        else $error("enable bits");
    a_reason_bits: assert property (rd_reason |=> (reg_rdata & 16'h60E1) == '0)
        else $error("reason bits");
    a_reset_enable: assert property (bus_reset ##1 rd_enable |=> reg_rdata == '0)
        else $error("enable kept");
    a_reset_irq: assert property (bus_reset |-> ##2 !dma_irq) else $error("irq kept");
    a_unread_set: assert property (data_port_unread && !bus_reset ##1 rd_reason |=>
        reg_rdata[4]) else $error("bit 4");
    a_busy_set: assert property (busy_poll_done && !bus_reset ##1 rd_reason |=>
        reg_rdata[3]) else $error("bit 3");
    cover property (dma_irq);
    cover property (bus_reset ##1 rd_enable);
    cover property (data_port_unread ##1 rd_reason);
endmodule // dma_event_chk
bind dma_interrupt_reason_enable dma_event_chk u_chk (.*);
`default_nettype wire

// ### cpu_model.sv
`timescale 1ns/1ps
`default_nettype none
module cpu_model (
    input  wire logic        sys_clk,
    output var  logic [7:0]  reg_addr,
    output var  logic [15:0] reg_wdata,
    output var  logic        reg_wr,
    output var  logic        reg_rd,
    input  wire logic [15:0] reg_rdata
);
    initial {reg_addr, reg_wdata, reg_wr, reg_rd} = '0;
    // released address and data lines go inverted and both strobes drop to zero, so stale values cannot pass
    task automatic acc(input logic w, input logic [7:0] a, input logic [15:0] d,
                       output logic [15:0] q);
        {reg_addr, reg_wdata, reg_wr, reg_rd} <= {a, d, w, !w};
        @(posedge sys_clk);
        {reg_addr, reg_wdata, reg_wr, reg_rd} <= {~a, ~d, 2'b00};
        @(posedge sys_clk);
        q = reg_rdata;
    endtask
endmodule // cpu_model
`default_nettype wire

// ### dma_interrupt_reason_enable_test.sv
`timescale 1ns/1ps
`default_nettype none
module dma_interrupt_reason_enable_test;
    import dma_event_pkg::*;
    logic        sys_clk = 0, rstn = 0, bus_reset = 0, command_done = 0, irq_pin = 0;
    logic        reg_wr, reg_rd, dma_irq;
    logic [7:0]  reg_addr;
    logic [15:0] reg_wdata, reg_rdata, q, ev = '0, m, w;
    dma_mode_t   dma_mode = DMA_MODE_OTHER;
    int          rsn = 0, enb = 0, fail_count = 0, tests_run = 0;
    always #20 sys_clk = ~sys_clk;
    cpu_model cpu (.sys_clk, .reg_addr, .reg_wdata, .reg_wr, .reg_rd, .reg_rdata);
    dma_interrupt_reason_enable dut (.sys_clk, .rstn, .bus_reset, .reg_addr, .reg_wdata,
        .reg_wr, .reg_rd, .reg_rdata, .dma_mode, .command_done, .dma_irq,
        .short_packet_abort_status(ev[15]), .generic_stop_done(ev[12]),
        .external_end_of_transfer(ev[11]), .internal_end_of_transfer(ev[10]),
        .transfer_count_done(ev[8]), .data_port_unread(ev[4]), .busy_poll_done(ev[3]),
        .taskfile_read_done(ev[2]), .device_irq_pin(irq_pin));
    task automatic chk(input string n, input logic [15:0] e, input logic [15:0] g);
        tests_run++;
        if (g !== e) begin
            fail_count++;
            $display("Error %s expected %h seen %h", n, e, g);
        end
    endtask
    task automatic rchk(input logic [7:0] a, input logic [15:0] e);
        cpu.acc(1'b0, a, 16'h0000, q);
        chk("rdata", e, q);
        chk("dma_irq", {15'h0000, |(rsn & enb)}, {15'h0000, dma_irq});
    endtask
    task automatic pulse(input logic [15:0] v, input dma_mode_t md);
        {ev, dma_mode, command_done} <= {v, md, 1'b1};
        @(posedge sys_clk);
        {ev, command_done} <= '0;
        rsn = rsn | v & 16'h941C | (md == DMA_MODE_GENERIC ? v & 16'h0800 : '0)
            | (md != DMA_MODE_OTHER ? v & 16'h0100 : '0);
    endtask
    task automatic summarize;
        $display("comparisons %0d mismatches %0d", tests_run, fail_count);
        if (fail_count == 0 && tests_run > 0) $display("[ PASS ]");
        else $display("[ FAIL ]");
        $finish;
    endtask
    initial begin
        void'($urandom(32'hE5B5));
        repeat (2) @(posedge sys_clk);
        rstn <= 1'b1;
        @(posedge sys_clk);
        rchk(8'h50, 16'h0000);
        rchk(8'h58, 16'h0000);
        cpu.acc(1'b1, 8'h54, 16'hFFFF, q);
        enb = 16'h1F1E;
        rchk(8'h54, 16'h1F1E);
        for (int i = 0; i < 30; i++) begin
            m = $urandom;
            pulse(m, i % 3 == 0 ? DMA_MODE_OTHER : i % 3 == 1 ? DMA_MODE_GENERIC
                : DMA_MODE_MASTER);
            rchk(8'h50, rsn);
            w = $urandom;
            cpu.acc(1'b1, 8'h50, w, q);
            rsn = rsn & ~(w & 16'h1F1E);
            if (i % 4 == 0) begin
                w = $urandom;
                cpu.acc(1'b1, 8'h54, w, q);
                enb = w & 16'h1F1E;
            end
        end
        irq_pin <= 1'b1;
        repeat (4) @(posedge sys_clk);
        rsn = rsn | 16'h0202;
        pulse(16'h0100, DMA_MODE_GENERIC);
        rchk(8'h50, rsn);
        irq_pin <= 1'b0;
        bus_reset <= 1'b1;
        @(posedge sys_clk);
        bus_reset <= 1'b0;
        {rsn, enb} = '0;
        rchk(8'h54, 16'h0000);
        rchk(8'h50, 16'h0000);
        summarize();
    end
    initial begin
        #100000;
        fail_count++;
        summarize();
    end
endmodule // dma_interrupt_reason_enable_test
`default_nettype wire
